/* File: inc/rsc_pkg.sv */
// Package with the register map, error identifiers, limits and types of the run start checker.
package rsc_pkg;

   // Byte offsets of the registers on the Wishbone bus.
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_STATUS    = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK  = 8'h0C;
   localparam logic [7:0] OFS_SPEED     = 8'h10;
   localparam logic [7:0] OFS_RAMP_UP   = 8'h14;
   localparam logic [7:0] OFS_RAMP_DN   = 8'h18;
   localparam logic [7:0] OFS_MAX_SPEED = 8'h1C;
   localparam logic [7:0] OFS_REF_SPEED = 8'h20;
   localparam logic [7:0] OFS_CHG_P     = 8'h24;
   localparam logic [7:0] OFS_CHG_M     = 8'h28;
   localparam logic [7:0] OFS_CUT_P     = 8'h2C;
   localparam logic [7:0] OFS_CUT_M     = 8'h30;
   localparam logic [7:0] OFS_TGT_RANGE = 8'h34;
   localparam logic [7:0] OFS_TARGET    = 8'h38;
   localparam logic [7:0] OFS_WR_LO     = 8'h3C;
   localparam logic [7:0] OFS_WR_HI     = 8'h40;
   localparam logic [7:0] OFS_ROT_END   = 8'h44;

   // Parameter words form one block; each index follows from its offset.
   localparam int CFG_NUM      = (OFS_ROT_END - OFS_SPEED) / 4 + 1;
   localparam int IX_SPEED     = (OFS_SPEED - OFS_SPEED) / 4;
   localparam int IX_RAMP_UP   = (OFS_RAMP_UP - OFS_SPEED) / 4;
   localparam int IX_RAMP_DN   = (OFS_RAMP_DN - OFS_SPEED) / 4;
   localparam int IX_MAX_SPEED = (OFS_MAX_SPEED - OFS_SPEED) / 4;
   localparam int IX_REF_SPEED = (OFS_REF_SPEED - OFS_SPEED) / 4;
   localparam int IX_CHG_P     = (OFS_CHG_P - OFS_SPEED) / 4;
   localparam int IX_CHG_M     = (OFS_CHG_M - OFS_SPEED) / 4;
   localparam int IX_CUT_P     = (OFS_CUT_P - OFS_SPEED) / 4;
   localparam int IX_CUT_M     = (OFS_CUT_M - OFS_SPEED) / 4;
   localparam int IX_TGT_RANGE = (OFS_TGT_RANGE - OFS_SPEED) / 4;
   localparam int IX_TARGET    = (OFS_TARGET - OFS_SPEED) / 4;
   localparam int IX_WR_LO     = (OFS_WR_LO - OFS_SPEED) / 4;
   localparam int IX_WR_HI     = (OFS_WR_HI - OFS_SPEED) / 4;
   localparam int IX_ROT_END   = (OFS_ROT_END - OFS_SPEED) / 4;

   // Control, status and interrupt field positions.
   localparam int CTRL_START_BIT  = 0;
   localparam int CTRL_MODE_LSB   = 1;
   localparam int CTRL_ROT_BIT    = 4;
   localparam int CTRL_DIRM_BIT   = 5;
   localparam int ST_VALID_BIT    = 16;
   localparam int ST_BUSY_BIT     = 17;
   localparam int ST_OK_BIT       = 18;
   localparam int IRQ_ACCEPT_BIT  = 0;
   localparam int IRQ_REJECT_BIT  = 1;
   localparam int IRQ_W           = 2;

   // Operating modes and reset values.
   localparam logic [2:0]  MODE_REL      = 3'h4;
   localparam logic [2:0]  MODE_ABS      = 3'h5;
   localparam logic [2:0]  RST_MODE      = 3'h5;
   localparam logic [31:0] RST_MAX_SPEED = 32'h0000_03E8;
   localparam logic [31:0] RST_REF_SPEED = 32'h0000_0064;
   localparam logic [31:0] RST_TGT_RANGE = 32'h0000_0032;

   // Limits of the run parameters, in pulses, pulses/s and pulses/s^2.
   localparam logic signed [35:0] SPEED_ABS_MAX = 36'h0_000F_4240;
   localparam logic signed [35:0] RAMP_MIN      = 36'h0_0000_0001;
   localparam logic signed [35:0] RAMP_MAX      = 36'h0_0001_86A0;
   localparam logic signed [35:0] DIFF_MAX      = 36'h0_05F5_E100;
   localparam logic signed [35:0] COORD_LIM     = 36'h0_1DCD_6500;

   // Event classes and numbers of the error identifier.
   localparam logic [7:0] CLS_SPEED   = 8'h32;
   localparam logic [7:0] CLS_DIFF    = 8'h33;
   localparam logic [7:0] CLS_TARGET  = 8'h34;
   localparam logic [7:0] CLS_TRAVEL  = 8'h35;
   localparam logic [7:0] NUM_SPEED   = 8'h02;
   localparam logic [7:0] NUM_UP      = 8'h03;
   localparam logic [7:0] NUM_DN      = 8'h04;
   localparam logic [7:0] NUM_REF     = 8'h06;
   localparam logic [7:0] NUM_DMAX    = 8'h01;
   localparam logic [7:0] NUM_CUTMIN  = 8'h04;
   localparam logic [7:0] NUM_CHGMIN  = 8'h05;
   localparam logic [7:0] NUM_SWLIM   = 8'h01;
   localparam logic [7:0] NUM_ROT     = 8'h02;
   localparam logic [7:0] NUM_DIST    = 8'h03;
   localparam logic [7:0] NUM_LOWABS  = 8'h04;
   localparam logic [7:0] NUM_WRANGE  = 8'h06;
   localparam logic [7:0] NUM_TOGO_LO = 8'h01;
   localparam logic [7:0] NUM_TOGO_HI = 8'h02;
   localparam logic [7:0] NUM_CUT_P   = 8'h03;
   localparam logic [7:0] NUM_CUT_M   = 8'h04;
   localparam logic [7:0] NUM_LAST_P  = 8'h05;
   localparam logic [7:0] NUM_LAST_M  = 8'h06;

   // Checker sequence; Gray coded along idle, evaluate, done.
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_EVAL = 2'b01, ST_DONE = 2'b11} rsc_state_e;

   // Axis state supplied by the positioning core.
   typedef struct packed {
      logic [31:0] actPos;
      logic [31:0] distToGo;
   } rsc_axis_s;

   // Verdict handed to the positioning core.
   typedef struct packed {
      logic        runStart;
      logic        errValid;
      logic [15:0] errId;
   } rsc_result_s;

   // Complete state of the checker.
   typedef struct packed {
      rsc_state_e               state;
      logic [CFG_NUM-1:0][31:0] cfg;
      logic [2:0]               mode;
      logic                     rotary;
      logic                     dirMinus;
      logic [IRQ_W-1:0]         irqStat;
      logic [IRQ_W-1:0]         irqMask;
      rsc_result_s              result;
      logic                     lastOk;
      logic                     irq;
      logic                     ack;
      logic [31:0]              rdData;
   } rsc_regs_s;

   localparam logic [CFG_NUM-1:0][31:0] CFG_RESET = '{IX_MAX_SPEED: RST_MAX_SPEED,
      IX_REF_SPEED: RST_REF_SPEED, IX_TGT_RANGE: RST_TGT_RANGE, default: 32'h0000_0000};

   localparam rsc_regs_s REGS_RESET = '{state: ST_IDLE, cfg: CFG_RESET, mode: RST_MODE,
      default: '0};

endpackage

/* File: verilog/rsc_run_start_checker.sv */
// Run start checker: validates positioning run parameters behind a Wishbone register file.
// Behaviour
// - Each error identifier is a class byte above a number byte and appears on the status output.
// - A speed of zero or above 1000000 pulses/s or above the configured maximum gives 32h/02h.
// - A ramp-up rate outside 1 to 100000 pulses/s^2 gives 32h/03h.
// - A ramp-down rate outside 1 to 100000 pulses/s^2 gives 32h/04h.
// - A speed below the configured reference speed gives 32h/06h.
// - Any changeover or cut-off difference above ten to the eighth gives 33h/01h.
// - A cut-off difference shorter than half the target range gives 33h/04h.
// - A changeover difference shorter than half the target range gives 33h/05h.
// - A linear absolute target outside the limit switch range, limits inside, gives 34h/01h.
// - A rotary target not above zero and below the rotary end gives 34h/02h.
// - A relative distance that is not positive gives 34h/03h.
// - A resulting target not above minus five times ten to the eighth gives 34h/04h.
// - A linear resulting target outside the working range widened by half the target range gives 34h/06h.
// - Target plus distance to go below minus or above plus 5e8 gives 35h/01h or 35h/02h.
// - A distance not above the cut-off difference of its direction gives 35h/03h or 35h/04h.
// - On a linear axis, a last reachable limit too close to the position gives 35h/05h plus or 35h/06h minus.
//
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module rsc_run_start_checker
(
   // System clock and asynchronous active-low reset.
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // Classic Wishbone slave.
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [7:0]            wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output var  logic [31:0]           wb_dat_o,
   output var  logic                  wb_ack_o,
   // Axis state from the positioning core.
   input  wire rsc_pkg::rsc_axis_s    axisState,
   // Verdict towards the positioning core.
   output var  rsc_pkg::rsc_result_s  runResult,
   // Level interrupt.
   output var  logic                  irq
);

   rsc_pkg::rsc_regs_s q;
   rsc_pkg::rsc_regs_s d;

   // Sign extension of a coordinate into the wide compare domain.
   function automatic logic signed [35:0] sext(input logic [31:0] v);
      sext = {{4{v[31]}}, v};
   endfunction

   // Zero extension of a magnitude into the wide compare domain.
   function automatic logic signed [35:0] zext(input logic [31:0] v);
      zext = {4'h0, v};
   endfunction

   // Builds an identifier with the class in the upper byte.
   function automatic logic [15:0] errCode(input logic [7:0] cls, input logic [7:0] num);
      errCode = {cls, num};
   endfunction

   // Merges write data into a word under the Wishbone byte selects.
   function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                             input logic [31:0] wdat,
                                             input logic [3:0]  sel);
      laneMerge = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            laneMerge[8*i +: 8] = wdat[8*i +: 8];
         end
      end
   endfunction

   // Runs every check in class and number order; the first failure wins, zero means accepted.
   // All arithmetic is 36 bits wide so that sums of two 32-bit coordinates cannot wrap.
   function automatic logic [15:0] checkRun(input rsc_pkg::rsc_regs_s r,
                                            input rsc_pkg::rsc_axis_s ax);
      logic signed [35:0] spd;
      logic signed [35:0] upR;
      logic signed [35:0] dnR;
      logic signed [35:0] chgP;
      logic signed [35:0] chgM;
      logic signed [35:0] cutP;
      logic signed [35:0] cutM;
      logic signed [35:0] tgtR;
      logic signed [35:0] half;
      logic signed [35:0] tgt;
      logic signed [35:0] act;
      logic signed [35:0] wrLo;
      logic signed [35:0] wrHi;
      logic signed [35:0] rotEnd;
      logic signed [35:0] resTgt;
      logic signed [35:0] travel;
      logic               rel;
      logic               plus;
      logic [15:0]        code;
      spd    = zext(r.cfg[rsc_pkg::IX_SPEED]);
      upR    = zext(r.cfg[rsc_pkg::IX_RAMP_UP]);
      dnR    = zext(r.cfg[rsc_pkg::IX_RAMP_DN]);
      chgP   = zext(r.cfg[rsc_pkg::IX_CHG_P]);
      chgM   = zext(r.cfg[rsc_pkg::IX_CHG_M]);
      cutP   = zext(r.cfg[rsc_pkg::IX_CUT_P]);
      cutM   = zext(r.cfg[rsc_pkg::IX_CUT_M]);
      tgtR   = zext(r.cfg[rsc_pkg::IX_TGT_RANGE]);
      half   = tgtR >>> 1;
      tgt    = sext(r.cfg[rsc_pkg::IX_TARGET]);
      act    = sext(ax.actPos);
      wrLo   = sext(r.cfg[rsc_pkg::IX_WR_LO]);
      wrHi   = sext(r.cfg[rsc_pkg::IX_WR_HI]);
      rotEnd = zext(r.cfg[rsc_pkg::IX_ROT_END]);
      rel    = (r.mode == rsc_pkg::MODE_REL);
      code   = 16'h0000;
      // Relative runs add the distance in the chosen direction; absolute runs take the target.
      if (rel)
      begin
         resTgt = r.dirMinus ? act - tgt : act + tgt;
      end
      else
      begin
         resTgt = tgt;
      end
      // Direction comes from the request except for a linear absolute run.
      plus = (rel || r.rotary) ? !r.dirMinus : (resTgt >= act);
      travel = plus ? resTgt - act : act - resTgt;
      // A rotary absolute run wraps through the rotary end rather than moving backwards.
      if (r.rotary && !rel && travel < 0)
      begin
         travel = travel + rotEnd;
      end
      if (spd == 0 || spd > rsc_pkg::SPEED_ABS_MAX || spd > zext(r.cfg[rsc_pkg::IX_MAX_SPEED]))
         code = errCode(rsc_pkg::CLS_SPEED, rsc_pkg::NUM_SPEED);
      else if (upR < rsc_pkg::RAMP_MIN || upR > rsc_pkg::RAMP_MAX)
         code = errCode(rsc_pkg::CLS_SPEED, rsc_pkg::NUM_UP);
      else if (dnR < rsc_pkg::RAMP_MIN || dnR > rsc_pkg::RAMP_MAX)
         code = errCode(rsc_pkg::CLS_SPEED, rsc_pkg::NUM_DN);
      else if (spd < zext(r.cfg[rsc_pkg::IX_REF_SPEED]))
         code = errCode(rsc_pkg::CLS_SPEED, rsc_pkg::NUM_REF);
      else if (chgP > rsc_pkg::DIFF_MAX || chgM > rsc_pkg::DIFF_MAX ||
               cutP > rsc_pkg::DIFF_MAX || cutM > rsc_pkg::DIFF_MAX)
         code = errCode(rsc_pkg::CLS_DIFF, rsc_pkg::NUM_DMAX);
      else if ((cutP <<< 1) < tgtR || (cutM <<< 1) < tgtR)
         code = errCode(rsc_pkg::CLS_DIFF, rsc_pkg::NUM_CUTMIN);
      else if ((chgP <<< 1) < tgtR || (chgM <<< 1) < tgtR)
         code = errCode(rsc_pkg::CLS_DIFF, rsc_pkg::NUM_CHGMIN);
      else if (!rel && !r.rotary && (tgt < wrLo || tgt > wrHi))
         code = errCode(rsc_pkg::CLS_TARGET, rsc_pkg::NUM_SWLIM);
      else if (!rel && r.rotary && (tgt <= 0 || tgt >= rotEnd))
         code = errCode(rsc_pkg::CLS_TARGET, rsc_pkg::NUM_ROT);
      else if (rel && tgt <= 0)
         code = errCode(rsc_pkg::CLS_TARGET, rsc_pkg::NUM_DIST);
      else if (resTgt <= -rsc_pkg::COORD_LIM)
         code = errCode(rsc_pkg::CLS_TARGET, rsc_pkg::NUM_LOWABS);
      else if (!r.rotary && (resTgt < wrLo - half || resTgt > wrHi + half))
         code = errCode(rsc_pkg::CLS_TARGET, rsc_pkg::NUM_WRANGE);
      else if (resTgt + sext(ax.distToGo) < -rsc_pkg::COORD_LIM)
         code = errCode(rsc_pkg::CLS_TRAVEL, rsc_pkg::NUM_TOGO_LO);
      else if (resTgt + sext(ax.distToGo) > rsc_pkg::COORD_LIM)
         code = errCode(rsc_pkg::CLS_TRAVEL, rsc_pkg::NUM_TOGO_HI);
      else if (plus && travel <= cutP)
         code = errCode(rsc_pkg::CLS_TRAVEL, rsc_pkg::NUM_CUT_P);
      else if (!plus && travel <= cutM)
         code = errCode(rsc_pkg::CLS_TRAVEL, rsc_pkg::NUM_CUT_M);
      else if (!r.rotary && plus && wrHi - act <= cutP)
         code = errCode(rsc_pkg::CLS_TRAVEL, rsc_pkg::NUM_LAST_P);
      else if (!r.rotary && !plus && act - wrLo <= cutM)
         code = errCode(rsc_pkg::CLS_TRAVEL, rsc_pkg::NUM_LAST_M);
      checkRun = code;
   endfunction

   // Next state: bus slave, checker sequence and interrupt status in one place.
   always_comb
   begin
      logic                      access;
      logic                      doWrite;
      logic [7:0]                wordAdr;
      logic [3:0]                cfgIdx;
      logic                      cfgHit;
      logic                      startReq;
      logic [rsc_pkg::IRQ_W-1:0] irqSet;
      logic [rsc_pkg::IRQ_W-1:0] irqClr;
      logic [15:0]               code;
      access   = 1'b0;
      doWrite  = 1'b0;
      wordAdr  = 8'h00;
      cfgIdx   = 4'h0;
      cfgHit   = 1'b0;
      startReq = 1'b0;
      irqSet   = '0;
      irqClr   = '0;
      code     = 16'h0000;
      d        = q;
      d.ack    = 1'b0;
      d.result.runStart = 1'b0;

      // One access per strobe; ack drops in the cycle after it was given. A write is
      // committed at the edge at which the master sees ack, while its request still stands.
      access  = wb_cyc_i && wb_stb_i && !q.ack;
      doWrite = wb_cyc_i && wb_stb_i && wb_we_i && q.ack;
      wordAdr = {wb_adr_i[7:2], 2'b00};
      cfgHit  = (wordAdr >= rsc_pkg::OFS_SPEED) && (wordAdr <= rsc_pkg::OFS_ROT_END);
      cfgIdx  = 4'((wordAdr - rsc_pkg::OFS_SPEED) >> 2);

      // Read data is registered with the ack; unmapped words read as zero.
      if (access)
      begin
         d.ack = 1'b1;
         if (cfgHit)
         begin
            d.rdData = q.cfg[cfgIdx];
         end
         else
         begin
            case (wordAdr)
               rsc_pkg::OFS_CTRL:
                  d.rdData = {26'h0, q.dirMinus, q.rotary, q.mode, 1'b0};
               rsc_pkg::OFS_STATUS:
                  d.rdData = {13'h0, q.lastOk, (q.state != rsc_pkg::ST_IDLE),
                              q.result.errValid, q.result.errId};
               rsc_pkg::OFS_IRQ_STAT:
                  d.rdData = {30'h0, q.irqStat};
               rsc_pkg::OFS_IRQ_MASK:
                  d.rdData = {30'h0, q.irqMask};
               default:
                  d.rdData = 32'h0000_0000;
            endcase
         end
      end

      // Writes to unmapped words are dropped.
      if (doWrite && cfgHit)
      begin
         d.cfg[cfgIdx] = laneMerge(q.cfg[cfgIdx], wb_dat_i, wb_sel_i);
      end
      if (doWrite && wb_sel_i[0])
      begin
         case (wordAdr)
            rsc_pkg::OFS_CTRL:
            begin
               // Mode and direction are frozen while a run request is being judged.
               if (q.state == rsc_pkg::ST_IDLE)
               begin
                  d.mode     = wb_dat_i[rsc_pkg::CTRL_MODE_LSB +: 3];
                  d.rotary   = wb_dat_i[rsc_pkg::CTRL_ROT_BIT];
                  d.dirMinus = wb_dat_i[rsc_pkg::CTRL_DIRM_BIT];
                  startReq   = wb_dat_i[rsc_pkg::CTRL_START_BIT];
               end
            end
            rsc_pkg::OFS_IRQ_STAT:
               irqClr = wb_dat_i[rsc_pkg::IRQ_W-1:0];
            rsc_pkg::OFS_IRQ_MASK:
               d.irqMask = wb_dat_i[rsc_pkg::IRQ_W-1:0];
            default:
            begin
            end
         endcase
      end

      // Checker sequence: the verdict is formed from the parameters and the live axis state.
      case (q.state)
         rsc_pkg::ST_IDLE:
         begin
            if (startReq)
            begin
               d.state = rsc_pkg::ST_EVAL;
            end
         end
         rsc_pkg::ST_EVAL:
         begin
            code = checkRun(q, axisState);
            // A failed check never pulses the start and its identifier holds until
            // the next evaluation replaces it.
            d.result.errId    = code;
            d.result.errValid = (code != 16'h0000);
            d.result.runStart = (code == 16'h0000);
            d.lastOk          = (code == 16'h0000);
            irqSet[rsc_pkg::IRQ_ACCEPT_BIT] = (code == 16'h0000);
            irqSet[rsc_pkg::IRQ_REJECT_BIT] = (code != 16'h0000);
            d.state = rsc_pkg::ST_DONE;
         end
         rsc_pkg::ST_DONE:
            d.state = rsc_pkg::ST_IDLE;
         default:
            d.state = rsc_pkg::ST_IDLE;
      endcase

      // Sticky events: a set in the same cycle as a clearing write is kept.
      d.irqStat = (q.irqStat & ~irqClr) | irqSet;
      d.irq     = |(d.irqStat & d.irqMask);
   end

   // The whole state is one register bank.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= rsc_pkg::REGS_RESET;
      end
      else
      begin
         q <= d;
      end
   end

   // Outputs come straight from the state flip-flops.
   assign wb_dat_o  = q.rdData;
   assign wb_ack_o  = q.ack;
   assign runResult = q.result;
   assign irq       = q.irq;

endmodule

`default_nettype wire

/* File: tb/rsc_run_start_checker_props.sv */
// Port checker of the run start checker, bound to its top module.
`timescale 1ns/1ns
`default_nettype none

module rsc_run_start_checker_props
(
   // Clock and reset.
   input wire logic                 clk,
   input wire logic                 rst_n,
   // Wishbone slave.
   input wire logic                 wb_cyc_i,
   input wire logic                 wb_stb_i,
   input wire logic                 wb_we_i,
   input wire logic [7:0]           wb_adr_i,
   input wire logic [3:0]           wb_sel_i,
   input wire logic [31:0]          wb_dat_i,
   input wire logic [31:0]          wb_dat_o,
   input wire logic                 wb_ack_o,
   // Axis state, verdict and interrupt.
   input wire rsc_pkg::rsc_axis_s   axisState,
   input wire rsc_pkg::rsc_result_s runResult,
   input wire logic                 irq
);
   // A start request is a control write with the start bit, taken at this edge.
   logic startReq;
   assign startReq = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
                     && wb_adr_i[7:2] == 6'h00 && wb_dat_i[0];

   // All properties share the one clock and its reset.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   property p_ackFollows;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ackFollows: assert property (p_ackFollows) else $error("ack missing after request");
   property p_ackSingle;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ackSingle: assert property (p_ackSingle) else $error("ack longer than one cycle");
   property p_verdictDue;
      startReq |-> ##2 (runResult.runStart || runResult.errValid);
   endproperty
   a_verdictDue: assert property (p_verdictDue) else $error("no verdict after start");
   property p_startPulse;
      runResult.runStart |=> !runResult.runStart;
   endproperty
   a_startPulse: assert property (p_startPulse) else $error("start pulse too long");
   property p_startCause;
      runResult.runStart |-> $past(startReq, 2);
   endproperty
   a_startCause: assert property (p_startCause) else $error("start without request");
   property p_noMotionOnError;
      runResult.runStart |-> !runResult.errValid;
   endproperty
   a_noMotionOnError: assert property (p_noMotionOnError) else $error("start with error");
   property p_idMatchesFlag;
      runResult.errValid == (runResult.errId != 16'h0000);
   endproperty
   a_idMatchesFlag: assert property (p_idMatchesFlag) else $error("error flag mismatch");
   property p_errHeld;
      !startReq ##1 !startReq |=> $stable(runResult.errId) && $stable(runResult.errValid);
   endproperty
   a_errHeld: assert property (p_errHeld) else $error("error changed without request");

   // Main scenarios: an accepted run, a travel rejection and an interrupt.
   c_start: cover property (runResult.runStart);
   c_reject: cover property (runResult.errValid && runResult.errId[15:8] == 8'h35);
   c_irq: cover property (irq);
endmodule

bind rsc_run_start_checker rsc_run_start_checker_props i_rsc_run_start_checker_props
(
   .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .axisState(axisState), .runResult(runResult), .irq(irq)
);

`default_nettype wire

/* File: tb/rsc_run_start_checker_tb_top.sv */
// Self-checking testbench of the run start checker.
`timescale 1ns/1ns
`default_nettype none

module rsc_run_start_checker_tb_top;
   // One case: control bits, one override on the valid base set, axis state, expected id.
   typedef struct packed {
      logic [7:0]  ctrl;
      logic [7:0]  ofs;
      logic [31:0] val;
      logic [31:0] act;
      logic [31:0] togo;
      logic [15:0] expId;
   } rsc_case_s;

   logic                clk;
   logic                rst_n;
   logic                wbCyc;
   logic                wbStb;
   logic                wbWe;
   logic [7:0]          wbAdr;
   logic [31:0]         wbDatW;
   logic [31:0]         wbDatR;
   logic                wbAck;
   logic                irq;
   logic [31:0]         rd;
   rsc_pkg::rsc_axis_s  axis;
   rsc_pkg::rsc_result_s result;
   rsc_case_s           cs [22];
   logic [31:0]         base [14];
   logic [7:0]          rOfs [8] = '{rsc_pkg::OFS_CTRL, rsc_pkg::OFS_STATUS,
      rsc_pkg::OFS_IRQ_STAT, rsc_pkg::OFS_IRQ_MASK, rsc_pkg::OFS_MAX_SPEED,
      rsc_pkg::OFS_REF_SPEED, rsc_pkg::OFS_TGT_RANGE, 8'h80};
   logic [31:0]         rExp [8] = '{32'hA, 32'h0, 32'h0, 32'h0, 32'h3E8, 32'h64, 32'h32, 32'h0};
   int                  badCount = 0;
   int                  checkCount = 0;
   int                  cycles = 0;

   rsc_run_start_checker i_rsc_run_start_checker (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wbCyc),
      .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDatW),
      .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .axisState(axis), .runResult(result), .irq(irq));

   // Clock of 50 MHz.
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Prints the counts and the verdict, then stops.
   task automatic endSim();
      $display("checks %0d mismatches %0d", checkCount, badCount);
      if (badCount == 0 && checkCount > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Compares one value with its expectation.
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] expv);
      checkCount++;
      if (seen !== expv)
      begin
         badCount++;
         $display("mismatch %s expected %h seen %h", name, expv, seen);
      end
   endtask

   // One classic cycle; the request stands until ack is sampled, so no latency is assumed.
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge clk);
      wbCyc  <= 1'b1;
      wbStb  <= 1'b1;
      wbWe   <= we;
      wbAdr  <= adr;
      wbDatW <= dat;
      do
         @(posedge clk);
      while (wbAck !== 1'b1);
      rd = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask

   // Reloads the valid base set, applies the override, starts and checks every view.
   task automatic runCase(input rsc_case_s c);
      for (int i = 0; i < rsc_pkg::CFG_NUM; i++)
         wb(1'b1, rsc_pkg::OFS_SPEED + 8'(4 * i), base[i]);
      wb(1'b1, c.ofs, c.val);
      axis <= '{actPos: c.act, distToGo: c.togo};
      wb(1'b1, rsc_pkg::OFS_CTRL, {24'h0, c.ctrl | 8'h01});
      // The verdict is registered one cycle after the start write is committed.
      @(posedge clk);
      #1;
      chk("runStart", 32'(result.runStart), 32'(c.expId == 16'h0));
      chk("errId", 32'(result.errId), 32'(c.expId));
      chk("irq", 32'(irq), 32'(c.expId != 16'h0));
      wb(1'b0, rsc_pkg::OFS_STATUS, 32'h0);
      chk("status", rd, c.expId == 16'h0 ? 32'h0004_0000 : {15'h0, 1'b1, c.expId});
      wb(1'b0, rsc_pkg::OFS_IRQ_STAT, 32'h0);
      chk("irq status", rd, c.expId == 16'h0 ? 32'h1 : 32'h2);
      wb(1'b1, rsc_pkg::OFS_IRQ_STAT, 32'h3);
      @(posedge clk);
      #1;
      chk("irq cleared", 32'(irq), 32'h0);
      chk("held errId", 32'(result.errId), 32'(c.expId));
   endtask

   // A hung handshake ends the run as a failure.
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 8000)
      begin
         badCount++;
         endSim();
      end
   end

   // Main sequence; override 44h rewrites the rotary end with its base value.
   initial
   begin
      {wbCyc, wbStb, wbWe, wbAdr, wbDatW} = '0;
      axis = '0;
      rst_n = 1'b0;
      base = '{32'h1F4, 32'hA, 32'hA, 32'h3E8, 32'h64, 32'h64, 32'h64, 32'h64, 32'h64,
               32'h32, 32'h3E8, 32'hFFFE_7960, 32'h0001_86A0, 32'hE10};
      cs = '{'{8'h08, 8'h44, 32'hE10, 32'h0, 32'h0, 16'h0000},
             '{8'h0A, 8'h38, 32'h186A0, 32'h0, 32'h0, 16'h0000},
             '{8'h08, 8'h10, 32'h0, 32'h0, 32'h0, 16'h3202},
             '{8'h08, 8'h10, 32'h3E9, 32'h0, 32'h0, 16'h3202},
             '{8'h08, 8'h14, 32'h0, 32'h0, 32'h0, 16'h3203},
             '{8'h08, 8'h18, 32'h186A1, 32'h0, 32'h0, 16'h3204},
             '{8'h08, 8'h10, 32'h63, 32'h0, 32'h0, 16'h3206},
             '{8'h08, 8'h2C, 32'h05F5_E101, 32'h0, 32'h0, 16'h3301},
             '{8'h08, 8'h30, 32'h18, 32'h0, 32'h0, 16'h3304},
             '{8'h08, 8'h28, 32'h18, 32'h0, 32'h0, 16'h3305},
             '{8'h0A, 8'h38, 32'h186A1, 32'h0, 32'h0, 16'h3401},
             '{8'h1A, 8'h38, 32'hE10, 32'h0, 32'h0, 16'h3402},
             '{8'h1A, 8'h38, 32'h0, 32'h0, 32'h0, 16'h3402},
             '{8'h08, 8'h38, 32'h0, 32'h0, 32'h0, 16'h3403},
             '{8'h28, 8'h44, 32'hE10, 32'hE232_9CF4, 32'h0, 16'h3404},
             '{8'h08, 8'h44, 32'hE10, 32'h0001_831C, 32'h0, 16'h3406},
             '{8'h08, 8'h44, 32'hE10, 32'h0, 32'h1DCD_6119, 16'h3502},
             '{8'h28, 8'h44, 32'hE10, 32'h0, 32'hE232_9EE7, 16'h3501},
             '{8'h08, 8'h38, 32'h64, 32'h0, 32'h0, 16'h3503},
             '{8'h28, 8'h38, 32'h64, 32'h0, 32'h0, 16'h3504},
             '{8'h08, 8'h38, 32'h6E, 32'h0001_863C, 32'h0, 16'h3505},
             '{8'h28, 8'h38, 32'h6E, 32'hFFFE_79C4, 32'h0, 16'h3506}};
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rOfs[i])
      begin
         wb(1'b0, rOfs[i], 32'h0);
         chk("reset value", rd, rExp[i]);
      end
      wb(1'b1, rsc_pkg::OFS_IRQ_MASK, 32'h2);
      wb(1'b0, rsc_pkg::OFS_IRQ_MASK, 32'h0);
      chk("irq mask", rd, 32'h2);
      foreach (cs[i])
         runCase(cs[i]);
      endSim();
   end
endmodule

`default_nettype wire
